//--- rtl/cond_pkg.sv
// ==========================================================
// counter input conditioning: shared constants
package cond_pkg;

  // ==========================================================
  // clock and channel counts
  localparam int NCH = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DB_TIMER_W = 22;
  localparam int CH_FLD_W = 8;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CH_CFG_OFS = 8'h00;
  localparam logic [7:0] MAP_CFG_OFS = 8'h04;
  localparam logic [7:0] CNT_LATCH_OFS = 8'h08;
  localparam logic [7:0] CNT_LIVE_OFS = 8'h0C;
  localparam logic [7:0] LEVEL_OFS = 8'h10;

  // ==========================================================
  // field positions inside one channel byte of the channel config
  localparam int MODE_LSB = 0;
  localparam int INV_BIT = 2;
  localparam int DB_LSB = 4;
  // field positions of the mapped-input config
  localparam int MAP_SEL_LSB = 0;
  localparam int LATCH_BIT = 2;
  localparam int GATE_BIT = 3;
  localparam int DECR_BIT = 4;

  // ==========================================================
  // reset values and writable masks
  localparam logic [31:0] CH_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] MAP_CFG_RST = 32'h0000_0001;
  localparam logic [31:0] CH_CFG_MASK = 32'hF7F7_F7F7;
  localparam logic [31:0] MAP_CFG_MASK = 32'h0000_001F;

  // filter choice per channel
  typedef enum logic [1:0] {FLT_BYPASS, FLT_AFTER, FLT_BEFORE, FLT_SPARE} filt_t;

  // ==========================================================
  // sixteen debounce intervals in ns, shortest to longest
  localparam int DB_TIME_NS [16] = '{
    500, 1500, 3500, 7500, 15500, 31500, 63500, 127500,
    255500, 511500, 1023500, 2047500, 4095500, 8191500, 16383500, 25500000
  };

  // interval in clock cycles, rounded up, shortened by a right shift
  function automatic logic [DB_TIMER_W-1:0] db_cycles(input logic [3:0] idx, input int shift);
    int c;
    c = (DB_TIME_NS[idx] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    c = c >>> shift;
    if (c < 1)
    begin
      c = 1;
    end
    return c[DB_TIMER_W-1:0];
  endfunction : db_cycles

endpackage : cond_pkg

//--- rtl/counter_input_conditioning.sv
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps

module counter_input_conditioning #(
  parameter int OWN_CH = 0,
  parameter int DB_SHIFT = 0
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [3:0] CNT_IN,
  input wire logic SCAN_START
);

  // ==========================================================
  // state
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q, prev_d;
  logic [3:0] out_q, out_d;
  logic [3:0] out_prev_q, out_prev_d;
  logic [cond_pkg::DB_TIMER_W-1:0] tmr_q [cond_pkg::NCH];
  logic [cond_pkg::DB_TIMER_W-1:0] tmr_d [cond_pkg::NCH];
  logic [cond_pkg::DB_TIMER_W-1:0] lim_c [cond_pkg::NCH];
  logic [3:0] in_c;
  logic [31:0] ch_cfg_q, ch_cfg_d;
  logic [31:0] map_cfg_q, map_cfg_d;
  logic [31:0] count_q, count_d;
  logic [31:0] latch_q, latch_d;
  logic dph_q, dph_d;
  logic dwr_q, dwr_d;
  logic [7:0] daddr_q, daddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q;
  logic take_c;
  logic [1:0] map_c;
  logic gate_open_c;
  logic own_rise_c;
  logic map_rise_c;

  // ==========================================================
  // field helpers
  function automatic logic [7:0] ch_fld(input logic [31:0] cfg, input int ch);
    return cfg[ch*cond_pkg::CH_FLD_W +: cond_pkg::CH_FLD_W];
  endfunction : ch_fld

  function automatic cond_pkg::filt_t ch_mode(input logic [31:0] cfg, input int ch);
    logic [7:0] f;
    f = ch_fld(cfg, ch);
    return cond_pkg::filt_t'(f[cond_pkg::MODE_LSB +: 2]);
  endfunction : ch_mode

  function automatic logic rising(input logic [3:0] now, input logic [3:0] was,
                                  input logic [1:0] sel);
    return now[sel] & ~was[sel];
  endfunction : rising

  // ==========================================================
  // input synchroniser, the first stage feeds only the second
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= CNT_IN;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // debounce per channel
  // a change restarts the stability timer; the timer saturates at the
  // interval so a long quiet input costs no extra width
  always_comb
  begin
    logic [7:0] fld;
    fld = 8'h00;
    prev_d = prev_q;
    out_d = out_q;
    out_prev_d = out_q;
    in_c = 4'h0;
    for (int i = 0; i < cond_pkg::NCH; i++)
    begin
      // one channel byte, held locally since a call result cannot be bit-selected
      fld = ch_fld(ch_cfg_q, i);
      in_c[i] = sync2_q[i] ^ fld[cond_pkg::INV_BIT];
      lim_c[i] = cond_pkg::db_cycles(fld[cond_pkg::DB_LSB +: 4], DB_SHIFT);
      prev_d[i] = in_c[i];
      if (in_c[i] != prev_q[i])
      begin
        tmr_d[i] = '0;
      end
      else if (tmr_q[i] >= lim_c[i])
      begin
        tmr_d[i] = tmr_q[i];
      end
      else
      begin
        tmr_d[i] = tmr_q[i] + {{(cond_pkg::DB_TIMER_W-1){1'b0}}, 1'b1};
      end
      case (ch_mode(ch_cfg_q, i))
        cond_pkg::FLT_BYPASS:
        begin
          out_d[i] = in_c[i];
        end
        cond_pkg::FLT_AFTER:
        begin
          if (tmr_d[i] >= lim_c[i])
          begin
            out_d[i] = in_c[i];
          end
        end
        cond_pkg::FLT_BEFORE:
        begin
          if (tmr_q[i] >= lim_c[i])
          begin
            out_d[i] = in_c[i];
          end
        end
        default:
        begin
          // spare code behaves as bypass
          out_d[i] = in_c[i];
        end
      endcase
    end
  end

  // debounce registers
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      prev_q <= 4'h0;
      out_q <= 4'h0;
      out_prev_q <= 4'h0;
      for (int i = 0; i < cond_pkg::NCH; i++)
      begin
        tmr_q[i] <= '0;
      end
    end
    else
    begin
      prev_q <= prev_d;
      out_q <= out_d;
      out_prev_q <= out_prev_d;
      for (int i = 0; i < cond_pkg::NCH; i++)
      begin
        tmr_q[i] <= tmr_d[i];
      end
    end
  end

  // ==========================================================
  // counter with mapped-input latch, gate and decrement
  // the gate reads the conditioned level, which already carries the
  // mapped channel's inverter, so falling-edge selection flips the gate
  always_comb
  begin
    map_c = map_cfg_q[cond_pkg::MAP_SEL_LSB +: 2];
    gate_open_c = !map_cfg_q[cond_pkg::GATE_BIT] || out_q[map_c];
    own_rise_c = rising(out_q, out_prev_q, 2'(OWN_CH));
    map_rise_c = rising(out_q, out_prev_q, map_c);
    count_d = count_q;
    if (gate_open_c)
    begin
      if (own_rise_c && !(map_cfg_q[cond_pkg::DECR_BIT] && map_rise_c))
      begin
        count_d = count_q + 32'h0000_0001;
      end
      else if (!own_rise_c && map_cfg_q[cond_pkg::DECR_BIT] && map_rise_c)
      begin
        count_d = count_q - 32'h0000_0001;
      end
    end
    latch_d = latch_q;
    if (map_cfg_q[cond_pkg::LATCH_BIT])
    begin
      if (map_rise_c)
      begin
        latch_d = count_q;
      end
    end
    else if (SCAN_START)
    begin
      latch_d = count_q;
    end
  end

  // counter registers
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      count_q <= 32'h0000_0000;
      latch_q <= 32'h0000_0000;
    end
    else
    begin
      count_q <= count_d;
      latch_q <= latch_d;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  // read data is built in the address phase from the next-state config,
  // so a read right after a write returns the written value
  always_comb
  begin
    take_c = HSEL && HTRANS[1] && HREADY;
    dph_d = take_c;
    dwr_d = take_c && HWRITE;
    daddr_d = take_c ? HADDR[7:0] : daddr_q;
    ch_cfg_d = ch_cfg_q;
    map_cfg_d = map_cfg_q;
    if (dph_q && dwr_q)
    begin
      case (daddr_q)
        cond_pkg::CH_CFG_OFS: ch_cfg_d = HWDATA & cond_pkg::CH_CFG_MASK;
        cond_pkg::MAP_CFG_OFS: map_cfg_d = HWDATA & cond_pkg::MAP_CFG_MASK;
        default: ch_cfg_d = ch_cfg_q;
      endcase
    end
    rdata_d = 32'h0000_0000;
    if (take_c && !HWRITE)
    begin
      case (HADDR[7:0])
        cond_pkg::CH_CFG_OFS: rdata_d = ch_cfg_d;
        cond_pkg::MAP_CFG_OFS: rdata_d = map_cfg_d;
        cond_pkg::CNT_LATCH_OFS: rdata_d = latch_q;
        cond_pkg::CNT_LIVE_OFS: rdata_d = count_q;
        cond_pkg::LEVEL_OFS: rdata_d = {28'h0000000, out_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      daddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      ch_cfg_q <= cond_pkg::CH_CFG_RST;
      map_cfg_q <= cond_pkg::MAP_CFG_RST;
    end
    else
    begin
      dph_q <= dph_d;
      dwr_q <= dwr_d;
      daddr_q <= daddr_d;
      rdata_q <= rdata_d;
      ready_q <= 1'b1;
      ch_cfg_q <= ch_cfg_d;
      map_cfg_q <= map_cfg_d;
    end
  end

  // HRDATA and HREADYOUT straight from flops, HRESP tied low; HSIZE is not decoded, word access only
  assign HRDATA = rdata_q;
  assign HREADYOUT = ready_q;
  assign HRESP = 1'b0;

endmodule : counter_input_conditioning

//--- tb/cond_assertions.sv
`timescale 1ns/10ps
// ==========================================================
// bus-side checks on the top ports
module cond_checks (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  logic rd;
  // a read address phase taken at this edge
  assign rd = HSEL && HTRANS[1] && HREADY && !HWRITE;
  property p_okay; HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rdy; $past(RESETN) |-> HREADYOUT; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state inserted");
  property p_rise; $rose(RESETN) |-> !HREADYOUT; endproperty
  a_rise: assert property (p_rise) else $error("ready early after reset");
  property p_rd0; !rd |=> HRDATA == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside read");
  property p_lvl; rd && HADDR[7:0] == cond_pkg::LEVEL_OFS |=> HRDATA[31:4] == 28'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("level above four channels");
  property p_map; rd && HADDR[7:0] == cond_pkg::MAP_CFG_OFS
    |=> (HRDATA & ~cond_pkg::MAP_CFG_MASK) == 32'h0; endproperty
  a_map: assert property (p_map) else $error("map config spare bits");
  property p_cfg; rd && HADDR[7:0] == cond_pkg::CH_CFG_OFS
    |=> (HRDATA & ~cond_pkg::CH_CFG_MASK) == 32'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("channel config spare bits");
  property p_hole; rd && HADDR[7:0] > 8'h10 |=> HRDATA == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule : cond_checks

//--- tb/counter_input_conditioning_tb.sv
`timescale 1ns/10ps
module counter_input_conditioning_tb;
  localparam int SH = 10;
  logic CLK_SYS = 1'b0;
  logic RESETN = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic SCAN_START = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
  logic [31:0] HRDATA, rd_q, r, exp;
  logic HREADY, HREADYOUT, HRESP, rdy_q;
  logic [3:0] CNT_IN;
  int fails = 0, n_compared = 0, k, n;
  assign HREADY = HREADYOUT;
  always #5 CLK_SYS = ~CLK_SYS;
  // bus values as seen just before each edge, free of races
  always @(posedge CLK_SYS)
  begin
    rd_q <= HRDATA;
    rdy_q <= HREADY;
  end
  counter_input_conditioning #(.OWN_CH(0), .DB_SHIFT(SH)) DUT (.CLK_SYS(CLK_SYS),
    .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CNT_IN(CNT_IN), .SCAN_START(SCAN_START));
  pulse_src SRC (.clk(CLK_SYS), .pins(CNT_IN));
  // ==========================================================
  // expectations and bus tasks
  function automatic int ncyc(input int i);
    ncyc = ((cond_pkg::DB_TIME_NS[i] + 9) / 10) >>> SH;
    if (ncyc < 1)
      ncyc = 1;
  endfunction : ncyc
  task automatic wrap_up;
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // bounded wait for hready; a hang ends the run
  task automatic hs;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge CLK_SYS);
      #1;
      if (rdy_q === 1'b1)
        return;
    end
    fails++;
    wrap_up;
  endtask : hs
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HSIZE <= 3'h2;
    hs;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    hs;
    r = rd_q;
  endtask : xfer
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    n_compared++;
    if (r !== e)
    begin
      fails++;
      $display("Error %0t: offset %h read %h want %h", $time, a, r, e);
    end
  endtask : chk
  task automatic scan;
    SCAN_START <= 1'b1;
    @(posedge CLK_SYS);
    SCAN_START <= 1'b0;
    #1;
  endtask : scan
  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h9C28BF50));
    repeat (8) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk(8'h00, cond_pkg::CH_CFG_RST);
    chk(8'h04, cond_pkg::MAP_CFG_RST);
    chk(8'h08, 32'h0);
    chk(8'h14, 32'h0);
    xfer(8'h0C, 1'b1, $urandom);
    chk(8'h0C, 32'h0);
    // random filter and interval fields, inverters left off so levels stay low
    r = $urandom & 32'hFBFB_FBFB;
    exp = r & cond_pkg::CH_CFG_MASK;
    xfer(8'h00, 1'b1, r);
    chk(8'h00, exp);
    // bypass with the longest interval: short pulses must still count
    xfer(8'h00, 1'b1, 32'hF0);
    n = ncyc(8);
    k = $urandom_range(8, 1);
    SRC.pulse(0, 2, 6, k);
    exp = k;
    chk(8'h0C, exp);
    xfer(8'h00, 1'b1, 32'h4);
    SRC.pulse(0, 3, 6, k);
    exp += k + 1;
    chk(8'h0C, exp);
    xfer(8'h00, 1'b1, 32'h0);
    scan;
    chk(8'h08, exp);
    xfer(8'h04, 1'b1, 32'h5);
    // move the count first so a missing mapped latch shows
    SRC.pulse(0, 2, 6, k);
    exp += k;
    SRC.pulse(1, 3, 6, 1);
    chk(8'h08, exp);
    SRC.pulse(0, 2, 6, k);
    scan;
    chk(8'h08, exp);
    exp += k;
    xfer(8'h04, 1'b1, 32'h9); // gate source unlike own channel
    SRC.pulse(0, 2, 6, k);
    chk(8'h0C, exp);
    SRC.hold(1, 1'b1);
    SRC.pulse(0, 2, 6, k);
    exp += k;
    chk(8'h0C, exp);
    xfer(8'h00, 1'b1, 32'h400);
    SRC.pulse(0, 2, 6, k);
    chk(8'h0C, exp);
    xfer(8'h00, 1'b1, 32'h0);
    SRC.hold(1, 1'b0);
    xfer(8'h04, 1'b1, 32'h12);
    SRC.pulse(2, 2, 6, k);
    exp -= k;
    chk(8'h0C, exp);
    // highest mapped channel selection
    xfer(8'h04, 1'b1, 32'h13);
    SRC.pulse(3, 2, 6, k);
    exp -= k;
    chk(8'h0C, exp);
    // interval index 8 lies between the glitches and the wanted pulse
    xfer(8'h00, 1'b1, 32'h81); // interval sized to the input
    SRC.pulse(0, n / 4, n / 4, 6);
    SRC.pulse(0, n / 4, 2 * n, 1);
    chk(8'h0C, exp);
    SRC.pulse(0, 2 * n, 2 * n, 1);
    exp += 1;
    chk(8'h0C, exp);
    xfer(8'h00, 1'b1, 32'h82); // interval covers a burst
    repeat (2)
    begin
      SRC.pulse(0, n / 4, n / 4, 4);
      SRC.pulse(0, n / 4, 2 * n, 1);
    end
    exp += 2;
    chk(8'h0C, exp);
    chk(8'h10, 32'h0);
    xfer(8'h00, 1'b1, 32'hF1);
    SRC.pulse(0, ncyc(15) / 2, 8, 1);
    chk(8'h0C, exp);
    wrap_up;
  end
endmodule : counter_input_conditioning_tb
bind counter_input_conditioning cond_checks u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

//--- tb/pulse_src.sv
`timescale 1ns/10ps
// ==========================================================
// pulse source and switch on the counter pins
module pulse_src (
  input wire logic clk,
  output logic [3:0] pins
);
  initial pins = 4'h0;
  // n pulses, hi cycles up then lo cycles down; push-pull, no release
  task automatic pulse(input int ch, input int hi, input int lo, input int n);
    repeat (n)
    begin
      pins[ch] <= 1'b1;
      repeat (hi) @(posedge clk);
      pins[ch] <= 1'b0;
      repeat (lo) @(posedge clk);
    end
    #1;
  endtask : pulse
  // steady level, long enough to pass the synchroniser
  task automatic hold(input int ch, input logic v);
    pins[ch] <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask : hold
endmodule : pulse_src
